// File: srcd_ref_cal.sv
// Reference-delay calibration control with its register file
//
// Function
// - With calibration disabled the delay output follows the manual delay setting.
// - With calibration enabled the delay output follows the calibration result only.
// - A calibration run starts only on a low-to-high change of the enable bit.
// - Averaging code 0..3 selects 4, 16, 64 or 256 measurements, default 1.
// - Length code 0..3 selects 4, 16, 64 or 256 cycles per accumulation.
// - A reference period above the limit gives a failed, unusable result.
// - A run ends within 384*19*4^(avg+len+2) cycles.
// - Status bit 17 reads 1 only while enabled and the run has finished.
// - Status bits 16:0 report the found delay code, valid only when complete.
// - Code bit 16 is clock inversion, 15:8 coarse step, 7:0 fine step.
`timescale 1ns/1ps
`default_nettype none
module srcd_ref_cal import srcd_pkg::*; #(
  parameter int BOUND_SCALE = SRCD_BOUND_SCALE
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        ref_pin,
  input  wire logic [16:0] manual_delay,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [23:0] reg_rdata,
  output logic      [16:0] delay_out,
  output logic             cal_enable,
  output logic             cal_complete
);
  // Scale must stay small enough that the shifted bound still fits 32 bits
  if (BOUND_SCALE < 1 || BOUND_SCALE > 65535) begin : g_bad_scale
    $error("BOUND_SCALE out of range");
  end

  srcd_state_t st_q;
  logic [7:0]  enable_q;
  logic [7:0]  config_q;
  logic        en_prev_q;
  logic [2:0]  ref_sync_q;
  logic [15:0] sum_q;
  logic [8:0]  cnt_q;
  logic [31:0] cyc_q;
  logic [16:0] result_q;
  logic        done_q;
  logic        fail_q;
  logic        start;
  logic        cal_en;
  logic [1:0]  avg_code;
  logic [1:0]  len_code;
  logic [8:0]  navg;
  logic [31:0] bound;
  logic [15:0] sum_next;
  logic [31:0] scaled;
  logic        s_valid;
  logic [7:0]  s_phase;
  logic        s_long;

  assign cal_en   = enable_q[SRCD_EN_BIT];
  assign avg_code = config_q[SRCD_AVG_LSB +: 2];
  assign len_code = config_q[SRCD_LEN_LSB +: 2];
  assign start    = cal_en && !en_prev_q;

  // Decoded averaging depth and run bound
  always_comb begin
    navg     = 9'(16'd1 << (2 * (avg_code + 2'd1)));
    bound    = 32'(BOUND_SCALE) << (2 * (avg_code + len_code + 2'(SRCD_BOUND_EXP)));
    sum_next = sum_q + {8'h00, s_phase};
    // Average phase as coarse.fine fraction of the window
    scaled   = ({16'h0000, sum_next} << (16 - 2 * (len_code + 2'd1)))
               >> (2 * (avg_code + 2'd1));
  end

  // Register writes; reserved bits are kept as written
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      enable_q <= SRCD_ENABLE_RST;
      config_q <= SRCD_CONFIG_RST;
    end else if (ce && reg_wr) begin
      if (reg_addr == SRCD_ENABLE_OFS) begin
        enable_q <= reg_wdata;
      end
      if (reg_addr == SRCD_CONFIG_OFS) begin
        config_q <= reg_wdata;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 24'h000000;
    end else if (ce && reg_rd) begin
      case (reg_addr)
        SRCD_ENABLE_OFS: reg_rdata <= {16'h0000, enable_q};
        SRCD_CONFIG_OFS: reg_rdata <= {16'h0000, config_q};
        // Flag gated by enable so a stale completion never shows
        SRCD_STATUS_OFS: reg_rdata <= {5'h00, fail_q, cal_en && done_q, result_q};
        default:         reg_rdata <= 24'h000000;
      endcase
    end
  end

  // Reference pin is asynchronous: two stages, then an edge stage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ref_sync_q <= 3'b000;
    end else if (ce) begin
      ref_sync_q <= {ref_sync_q[1:0], ref_pin};
    end
  end

  srcd_phase_meas u_meas (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .ce           (ce),
    .run          (st_q == SRCD_RUN),
    .ref_edge     (ref_sync_q[1] && !ref_sync_q[2]),
    .len_code     (len_code),
    .sample_valid (s_valid),
    .sample_phase (s_phase),
    .too_long     (s_long)
  );

  // Calibration sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q      <= SRCD_IDLE;
      en_prev_q <= 1'b0;
      sum_q     <= 16'h0000;
      cnt_q     <= 9'h000;
      cyc_q     <= 32'h00000000;
      result_q  <= 17'h00000;
      done_q    <= 1'b0;
      fail_q    <= 1'b0;
    end else if (ce) begin
      en_prev_q <= cal_en;
      if (!cal_en) begin
        st_q   <= SRCD_IDLE;
        done_q <= 1'b0;
      end else if (start) begin
        st_q   <= SRCD_RUN;
        done_q <= 1'b0;
        fail_q <= 1'b0;
        sum_q  <= 16'h0000;
        cnt_q  <= 9'h000;
        cyc_q  <= 32'h00000000;
      end else begin
        case (st_q)
          SRCD_RUN: begin
            cyc_q <= cyc_q + 32'h00000001;
            if (cyc_q + 32'h00000001 >= bound) begin
              // Out of time: give up rather than hang
              st_q     <= SRCD_DONE;
              done_q   <= 1'b1;
              fail_q   <= 1'b1;
              result_q <= 17'h00000;
            end else if (s_valid && s_long) begin
              st_q     <= SRCD_DONE;
              done_q   <= 1'b1;
              fail_q   <= 1'b1;
              result_q <= 17'h00000;
            end else if (s_valid) begin
              sum_q <= sum_next;
              cnt_q <= cnt_q + 9'h001;
              if (cnt_q + 9'h001 == navg) begin
                st_q     <= SRCD_DONE;
                done_q   <= 1'b1;
                result_q <= {1'b0, scaled[15:0]};
              end
            end
          end
          SRCD_DONE: st_q <= SRCD_DONE;
          SRCD_IDLE: st_q <= SRCD_IDLE;
          default:   st_q <= SRCD_IDLE;
        endcase
      end
    end
  end

  // Delay output select; calibration never glitches the manual path
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      delay_out    <= 17'h00000;
      cal_enable   <= 1'b0;
      cal_complete <= 1'b0;
    end else if (ce) begin
      delay_out    <= cal_en ? result_q : manual_delay;
      cal_enable   <= cal_en;
      cal_complete <= cal_en && done_q;
    end
  end

  property p_manual_path;
    @(posedge mclk) disable iff (sys_rst)
      (ce && !cal_en) |=> delay_out == $past(manual_delay);
  endproperty
  a_manual_path: assert property (p_manual_path) else $error("manual delay not passed");

  property p_cal_path;
    @(posedge mclk) disable iff (sys_rst)
      (ce && cal_en) |=> delay_out == $past(result_q);
  endproperty
  a_cal_path: assert property (p_cal_path) else $error("calibrated delay not used");

  property p_start_on_rise;
    @(posedge mclk) disable iff (sys_rst)
      (st_q != SRCD_RUN ##1 st_q == SRCD_RUN) |-> $past(start) && !$past(en_prev_q);
  endproperty
  a_start_on_rise: assert property (p_start_on_rise) else $error("run began without rise");

  property p_fail_long;
    @(posedge mclk) disable iff (sys_rst)
      (ce && cal_en && !start && st_q == SRCD_RUN && s_valid && s_long)
        |=> st_q == SRCD_DONE && fail_q && done_q;
  endproperty
  a_fail_long: assert property (p_fail_long) else $error("long period not failed");

  property p_bound;
    @(posedge mclk) disable iff (sys_rst)
      (st_q == SRCD_RUN) |-> cyc_q < bound;
  endproperty
  a_bound: assert property (p_bound) else $error("run exceeded bound");

  property p_complete_gated;
    @(posedge mclk) disable iff (sys_rst)
      (ce && reg_rd && reg_addr == SRCD_STATUS_OFS)
        |=> reg_rdata[SRCD_COMPLETE_BIT] == $past(cal_en && done_q);
  endproperty
  a_complete_gated: assert property (p_complete_gated) else $error("bad completion bit");

  property p_result_read;
    @(posedge mclk) disable iff (sys_rst)
      (ce && reg_rd && reg_addr == SRCD_STATUS_OFS) |=> reg_rdata[16:0] == $past(result_q);
  endproperty
  a_result_read: assert property (p_result_read) else $error("bad status code");

  property p_clear_done;
    @(posedge mclk) disable iff (sys_rst)
      (ce && (!cal_en || start)) |=> !done_q;
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("completion not cleared");

  property p_avg_count;
    @(posedge mclk) disable iff (sys_rst)
      (st_q == SRCD_RUN ##1 st_q == SRCD_DONE && !fail_q) |-> cnt_q == $past(navg);
  endproperty
  a_avg_count: assert property (p_avg_count) else $error("wrong sample count");

  c_start:   cover property (@(posedge mclk) disable iff (sys_rst) start);
  c_success: cover property (@(posedge mclk) disable iff (sys_rst) done_q && !fail_q);
  c_fail:    cover property (@(posedge mclk) disable iff (sys_rst) done_q && fail_q);
endmodule // srcd_ref_cal
`default_nettype wire

// File: srcd_pkg.sv
// Shared constants for the reference-delay calibration block
package srcd_pkg;
  // Register offsets
  localparam logic [11:0] SRCD_ENABLE_OFS = 12'h2b0;
  localparam logic [11:0] SRCD_CONFIG_OFS = 12'h2b1;
  localparam logic [11:0] SRCD_STATUS_OFS = 12'h2b2;
  // Reset values
  localparam logic [7:0]  SRCD_ENABLE_RST = 8'h00;
  localparam logic [7:0]  SRCD_CONFIG_RST = 8'h05;
  // Field positions
  localparam int SRCD_EN_BIT       = 0;
  localparam int SRCD_AVG_LSB      = 2;
  localparam int SRCD_LEN_LSB      = 0;
  localparam int SRCD_COMPLETE_BIT = 17;
  localparam int SRCD_FAIL_BIT     = 18;
  localparam int SRCD_INV_BIT      = 16;
  localparam int SRCD_COARSE_LSB   = 8;
  // Calibration bound: scale * 4^(avg + len + 2) cycles
  localparam int SRCD_BOUND_SCALE  = 384 * 19;
  localparam int SRCD_BOUND_EXP    = 2;
  // Longest reference period per accumulation-length code
  localparam logic [15:0] SRCD_PERIOD_LIM0 = 16'd128;
  localparam logic [15:0] SRCD_PERIOD_LIM1 = 16'd1664;
  localparam logic [15:0] SRCD_PERIOD_LIM2 = 16'd7808;
  localparam logic [15:0] SRCD_PERIOD_LIM3 = 16'd32384;
  typedef enum logic [1:0] {SRCD_IDLE, SRCD_RUN, SRCD_DONE} srcd_state_t;
endpackage

// File: srcd_phase_meas.sv
// Reference edge phase and period measurement
`timescale 1ns/1ps
`default_nettype none
module srcd_phase_meas import srcd_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        run,
  input  wire logic        ref_edge,
  input  wire logic [1:0]  len_code,
  output logic             sample_valid,
  output logic [7:0]       sample_phase,
  output logic             too_long
);
  logic [7:0]  phase_q;
  logic [15:0] period_q;
  logic        armed_q;
  logic [7:0]  len_last;
  logic [15:0] limit;

  // Accumulation length 4/16/64/256 and matching period limit
  always_comb begin
    len_last = 8'((16'd1 << (2 * (len_code + 2'd1))) - 16'd1);
    case (len_code)
      2'd0:    limit = SRCD_PERIOD_LIM0;
      2'd1:    limit = SRCD_PERIOD_LIM1;
      2'd2:    limit = SRCD_PERIOD_LIM2;
      default: limit = SRCD_PERIOD_LIM3;
    endcase
  end

  // Phase counter wraps once per accumulation window
  always_ff @(posedge mclk) begin
    if (sys_rst || (ce && !run)) begin
      phase_q <= 8'h00;
    end else if (ce) begin
      phase_q <= (phase_q == len_last) ? 8'h00 : phase_q + 8'h01;
    end
  end

  // Period counter saturates so a missing reference still reads as too long
  always_ff @(posedge mclk) begin
    if (sys_rst || (ce && !run)) begin
      period_q <= 16'h0000;
      armed_q  <= 1'b0;
    end else if (ce) begin
      if (ref_edge) begin
        period_q <= 16'h0001;
        armed_q  <= 1'b1;
      end else if (period_q != 16'hffff) begin
        period_q <= period_q + 16'h0001;
      end
    end
  end

  // First edge only arms; later edges yield a sample
  assign sample_valid = run && ref_edge && armed_q;
  assign sample_phase = phase_q;
  assign too_long     = period_q > limit;
endmodule // srcd_phase_meas
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the reference-delay calibration block
`timescale 1ns/1ps
`default_nettype none
module testbench import srcd_pkg::*;;
  localparam int BS = 64;
  logic        mclk = 0, sys_rst = 1, ce = 1, ref_pin = 0, reg_wr = 0, reg_rd = 0;
  logic        rd_seen = 0, cal_enable, cal_complete;
  logic [16:0] manual_delay = '0, lf = 17'h110ba, delay_out;
  logic [11:0] reg_addr = '0;
  logic [7:0]  reg_wdata = '0, cv;
  logic [23:0] reg_rdata, e, m;
  logic [23:0] q_exp[$], q_msk[$];
  logic [7:0]  cfgs[4] = '{8'h00, 8'h01, 8'h04, 8'h03};
  int          pers[4] = '{128, 16, 8, 256};
  int          n_mismatch = 0, compares = 0, ref_per = 0, rcnt = 0;

  // Short timeout so the overrun case stays quick
  srcd_ref_cal #(.BOUND_SCALE(BS)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .ref_pin(ref_pin),
    .manual_delay(manual_delay), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .delay_out(delay_out), .cal_enable(cal_enable), .cal_complete(cal_complete)
  );

  always #5 mclk = ~mclk;

  // Reference pulses two cycles wide; a zero period keeps the pin low
  initial forever begin
    @(posedge mclk);
    rcnt = (ref_per != 0 && rcnt + 1 < ref_per) ? rcnt + 1 : 0;
    #1 ref_pin = (ref_per != 0) && (rcnt < 2);
  end

  function automatic logic [16:0] nx(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction

  task chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
    compares++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Read data lands one edge after the strobe is taken
  always @(posedge mclk) begin
    if (rd_seen) begin
      e = q_exp.pop_front();
      m = q_msk.pop_front();
      chk("reg_rdata", e & m, reg_rdata & m);
    end
    rd_seen <= reg_rd && ce;
  end

  task clks(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1 reg_wr = 0;
  endtask

  task rd(input logic [11:0] a, input logic [23:0] ex, input logic [23:0] mk);
    @(posedge mclk);
    #1 reg_rd = 1;
    reg_addr = a;
    q_exp.push_back(ex);
    q_msk.push_back(mk);
    @(posedge mclk);
    #1 reg_rd = 0;
  endtask

  // Result bits below the phase field are zero, so they are checked exactly
  task cal(input logic [7:0] cfg, input int per);
    int lim, n;
    logic [23:0] mk;
    lim = BS * 4 ** (int'(cfg[3:2]) + int'(cfg[1:0]) + 2);
    mk = 24'hff0000 | ((24'h1 << (14 - 2 * cfg[1:0])) - 24'h1);
    n = 0;
    wr(SRCD_CONFIG_OFS, cfg);
    ref_per = per;
    wr(SRCD_ENABLE_OFS, 8'h01);
    while (cal_complete !== 1'b1 && n < lim) begin
      clks(1);
      n++;
    end
    chk("cal_time", 24'h0, {23'h0, n >= lim});
    rd(SRCD_STATUS_OFS, 24'h020000, mk);
    chk("delay_out", 24'h0, {7'h0, delay_out & mk[16:0]});
  endtask

  task wrap_up;
    $display("Checks made %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run of some four thousand cycles
  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    #1 sys_rst = 0;
    rd(SRCD_ENABLE_OFS, 24'h0, 24'hffffff);
    rd(SRCD_CONFIG_OFS, {16'h0, SRCD_CONFIG_RST}, 24'hffffff);
    wr(SRCD_STATUS_OFS, 8'hff);
    rd(SRCD_STATUS_OFS, 24'h0, 24'hffffff);
    rd(12'h2b3, 24'h0, 24'hffffff);
    repeat (4) begin
      lf = nx(lf);
      manual_delay = lf;
      clks(2);
      chk("delay_out", {7'h0, lf}, {7'h0, delay_out});
    end
    // Every averaging and length code, reserved bits random
    for (int i = 0; i < 16; i++) begin
      lf = nx(lf);
      cv = {lf[7:4], i[3:0]};
      wr(SRCD_CONFIG_OFS, cv);
      rd(SRCD_CONFIG_OFS, {16'h0, cv}, 24'hffffff);
    end
    // A write while the clock enable is low must leave no trace
    ce = 0;
    wr(SRCD_CONFIG_OFS, 8'h00);
    ce = 1;
    rd(SRCD_CONFIG_OFS, {16'h0, cv}, 24'hffffff);
    manual_delay = 17'h1ffff;
    cal(8'h00, 8);
    wr(SRCD_ENABLE_OFS, 8'h01);
    clks(3);
    chk("cal_complete", 24'h1, {23'h0, cal_complete});
    chk("cal_enable", 24'h1, {23'h0, cal_enable});
    wr(SRCD_ENABLE_OFS, 8'h00);
    clks(2);
    chk("cal_complete", 24'h0, {23'h0, cal_complete});
    chk("cal_enable", 24'h0, {23'h0, cal_enable});
    chk("delay_out", 24'h01ffff, {7'h0, delay_out});
    rd(SRCD_STATUS_OFS, 24'h0, 24'h020000);
    for (int i = 0; i < 4; i++) begin
      cal(cfgs[i], pers[i]);
      wr(SRCD_ENABLE_OFS, 8'h00);
    end
    // Period above the short-length limit fails long before the timeout
    wr(SRCD_CONFIG_OFS, 8'h00);
    ref_per = 200;
    wr(SRCD_ENABLE_OFS, 8'h01);
    clks(600);
    rd(SRCD_STATUS_OFS, 24'h040000, 24'hfdffff);
    wr(SRCD_ENABLE_OFS, 8'h00);
    // No reference at all: fail only once the bound has run out
    ref_per = 0;
    wr(SRCD_ENABLE_OFS, 8'h01);
    clks(990);
    rd(SRCD_STATUS_OFS, 24'h0, 24'h040000);
    clks(40);
    rd(SRCD_STATUS_OFS, 24'h040000, 24'h040000);
    wr(SRCD_ENABLE_OFS, 8'h00);
    // Reset in the middle of a run brings every output and register back to default
    wr(SRCD_ENABLE_OFS, 8'h01);
    clks(5);
    sys_rst = 1;
    clks(2);
    sys_rst = 0;
    chk("cal_enable", 24'h0, {23'h0, cal_enable});
    chk("delay_out", 24'h0, {7'h0, delay_out});
    chk("cal_complete", 24'h0, {23'h0, cal_complete});
    rd(SRCD_ENABLE_OFS, 24'h0, 24'hffffff);
    rd(SRCD_CONFIG_OFS, {16'h0, SRCD_CONFIG_RST}, 24'hffffff);
    rd(SRCD_STATUS_OFS, 24'h0, 24'hffffff);
    clks(3);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
